// file: pas_axis_status.sv
// stepping output axis status read-back: run control, position poll, clear and faults
module pas_axis_status
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output pas_pkg::pas_lbreq_t lbReq,
  input wire pas_pkg::pas_lbrsp_t lbRsp,
  output logic blockActive,
  output logic [31:0] currentStepPosition,
  output logic outputInProgress,
  output logic outputHalted,
  output logic faultFlag,
  output logic [3:0] faultCode,
  output logic irq
);
  import pas_pkg::*;

  typedef struct packed {
    pas_seq_t st;
    logic runRequest;
    logic clearLevel;
    logic clearPrev;
    logic clearPend;
    logic [7:0] slotIndex;
    logic [7:0] axisSelect;
    logic active;
    logic [31:0] position;
    logic moving;
    logic halted;
    logic fault;
    logic [3:0] code;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic irq;
    pas_lbreq_t lb;
  } pas_state_t;

  pas_state_t q;
  pas_state_t d;
  logic rdEn;
  logic wrEn;
  logic [ADDR_W-1:0] rdAddr;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] rdValue;
  logic [IRQ_W-1:0] events;
  logic clearDone;

  // register read mux, shared by the bus port
  function automatic logic [31:0] readReg(input logic [ADDR_W-1:0] a, input pas_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      CTRL_OFS:
      begin
        v[CTRL_RUN_BIT] = s.runRequest;
        v[CTRL_CLEAR_BIT] = s.clearLevel;
      end
      SELECT_OFS:
      begin
        v[SEL_SLOT_LSB +: 8] = s.slotIndex;
        v[SEL_AXIS_LSB +: 8] = s.axisSelect;
      end
      STATUS_OFS: v[3:0] = {s.fault, s.halted, s.moving, s.active};
      POSITION_OFS: v = s.position;
      FAULT_OFS: v[3:0] = s.code;
      IRQ_STATUS_OFS: v[IRQ_W-1:0] = s.irqStatus;
      IRQ_MASK_OFS: v[IRQ_W-1:0] = s.irqMask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // raise a fault and park the sequencer until the run request drops;
  // applied to the next-state copy so a bus write landing in the same cycle is kept
  function automatic pas_state_t raiseFault(input pas_state_t s, input logic [3:0] c);
    pas_state_t r;
    r = s;
    r.fault = 1'b1;
    r.code = c;
    r.st = SEQ_FAULT;
    r.lb.req = 1'b0;
    return r;
  endfunction

  assign rdValue = readReg(rdAddr, q);

  pas_ahb_port u_port
  (
    .clk(clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rdValue(rdValue),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .wrEn(wrEn),
    .wrAddr(wrAddr)
  );

  // outputs straight from the state register
  assign lbReq = q.lb;
  assign blockActive = q.active;
  assign currentStepPosition = q.position;
  assign outputInProgress = q.moving;
  assign outputHalted = q.halted;
  assign faultFlag = q.fault;
  assign faultCode = q.code;
  assign irq = q.irq;

  // next state: bus writes, sequencer, clear edge, interrupt status
  always_comb
  begin
    d = q;
    clearDone = 1'b0;
    events = '0;

    // software writes steer the block
    if (wrEn)
    begin
      unique case (wrAddr)
        CTRL_OFS:
        begin
          d.runRequest = hwdata[CTRL_RUN_BIT];
          d.clearLevel = hwdata[CTRL_CLEAR_BIT];
        end
        SELECT_OFS:
        begin
          d.slotIndex = hwdata[SEL_SLOT_LSB +: 8];
          d.axisSelect = hwdata[SEL_AXIS_LSB +: 8];
        end
        IRQ_MASK_OFS: d.irqMask = hwdata[IRQ_W-1:0];
        default: d.irqMask = q.irqMask; // read-only or unmapped: ignored
      endcase
    end

    if (!q.runRequest)
    begin
      // release drops the request and puts the status outputs back to their defaults; irq still follows the interrupt status
      d.st = SEQ_IDLE;
      d.active = 1'b0;
      d.position = POSITION_RESET;
      d.moving = 1'b0;
      d.halted = 1'b0;
      d.fault = 1'b0;
      d.code = NO_FAULT_VALUE;
      d.clearPend = 1'b0;
      d.lb.req = 1'b0; // a late ack after release is ignored in idle
    end
    else
    begin
      unique case (q.st)
        SEQ_IDLE:
        begin
          d.active = 1'b1;
          d.st = SEQ_CHECK;
        end
        SEQ_CHECK:
        begin
          // selection is validated and frozen for the whole run
          if (q.slotIndex > SLOT_MAX)
          begin
            d = raiseFault(d, FAULT_SLOT_RANGE);
          end
          else if (q.axisSelect < AXIS_MIN || q.axisSelect > AXIS_MAX)
          begin
            d = raiseFault(d, FAULT_AXIS_RANGE);
          end
          else
          begin
            d.lb.slot = q.slotIndex[4:0];
            d.lb.axis = 2'(q.axisSelect - AXIS_MIN);
            d.st = SEQ_ISSUE;
          end
        end
        SEQ_ISSUE:
        begin
          // a pending clear goes out ahead of the next poll
          d.lb.req = 1'b1;
          if (q.clearPend)
          begin
            d.lb.op = LB_OP_CLEAR;
            d.clearPend = 1'b0;
          end
          else
          begin
            d.lb.op = LB_OP_READ;
          end
          d.st = SEQ_WAIT;
        end
        SEQ_WAIT:
        begin
          // request held until the module answers
          if (lbRsp.ack)
          begin
            d.lb.req = 1'b0;
            if (!lbRsp.stepping)
            begin
              d = raiseFault(d, FAULT_NOT_STEPPING);
            end
            else if ({1'b0, q.lb.axis} >= lbRsp.axisCount)
            begin
              d = raiseFault(d, FAULT_AXIS_ABSENT);
            end
            else if (q.lb.op == LB_OP_CLEAR)
            begin
              // the count itself is kept and zeroed inside the module
              clearDone = 1'b1;
              d.st = SEQ_ISSUE;
            end
            else
            begin
              d.position = lbRsp.position;
              // a zero rate parks the axis as halted after its last pulse
              d.halted = lbRsp.halted;
              d.moving = lbRsp.emitting && !lbRsp.halted;
              d.st = SEQ_ISSUE;
            end
          end
        end
        SEQ_FAULT:
        begin
          d.lb.req = 1'b0;
        end
        default:
        begin
          d.st = SEQ_IDLE;
        end
      endcase
    end

    // edge detect; set placed after the sequencer so a new edge wins over its clear
    d.clearPrev = q.clearLevel;
    if (q.clearLevel && !q.clearPrev && q.active && q.runRequest)
    begin
      d.clearPend = 1'b1;
    end

    // sticky events, read clears, a new event in the same cycle survives
    events[IRQ_FAULT_BIT] = d.fault && !q.fault;
    events[IRQ_MOVE_BIT] = d.moving && !q.moving;
    events[IRQ_HALT_BIT] = d.halted && !q.halted;
    events[IRQ_CLEAR_BIT] = clearDone;
    if (rdEn && rdAddr == IRQ_STATUS_OFS)
    begin
      d.irqStatus = events;
    end
    else
    begin
      d.irqStatus = q.irqStatus | events;
    end
    d.irq = |(d.irqStatus & d.irqMask);
  end

  // single state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '{
        st: SEQ_IDLE,
        runRequest: 1'b0,
        clearLevel: 1'b0,
        clearPrev: 1'b0,
        clearPend: 1'b0,
        slotIndex: SLOT_RESET,
        axisSelect: AXIS_RESET,
        active: 1'b0,
        position: POSITION_RESET,
        moving: 1'b0,
        halted: 1'b0,
        fault: 1'b0,
        code: NO_FAULT_VALUE,
        irqStatus: '0,
        irqMask: IRQ_MASK_RESET,
        irq: 1'b0,
        lb: '{req: 1'b0, op: LB_OP_READ, slot: 5'h00, axis: 2'h0}
      };
    end
    else
    begin
      q <= d;
    end
  end
endmodule

// file: pas_pkg.sv
// package of shared constants and types, plus the bus slave front end for the axis read-back block
package pas_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SELECT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] POSITION_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FAULT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h18;
  // field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned SEL_SLOT_LSB = 0;
  localparam int unsigned SEL_AXIS_LSB = 8;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FAULT_BIT = 0;
  localparam int unsigned IRQ_MOVE_BIT = 1;
  localparam int unsigned IRQ_HALT_BIT = 2;
  localparam int unsigned IRQ_CLEAR_BIT = 3;
  // reset values and ranges
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] SLOT_MAX = 8'h1F;
  localparam logic [7:0] AXIS_RESET = 8'h01;
  localparam logic [7:0] AXIS_MIN = 8'h01;
  localparam logic [7:0] AXIS_MAX = 8'h04;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
  // fault codes
  localparam logic [3:0] NO_FAULT_VALUE = 4'h0;
  localparam logic [3:0] FAULT_SLOT_RANGE = 4'h1;
  localparam logic [3:0] FAULT_AXIS_RANGE = 4'h2;
  localparam logic [3:0] FAULT_NOT_STEPPING = 4'h3;
  localparam logic [3:0] FAULT_AXIS_ABSENT = 4'h4;
  // ahb and local bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] LB_OP_READ = 2'h0;
  localparam logic [1:0] LB_OP_CLEAR = 2'h1;

  typedef enum logic [2:0] {SEQ_IDLE, SEQ_CHECK, SEQ_ISSUE, SEQ_WAIT, SEQ_FAULT} pas_seq_t;

  // request toward the stepping output module
  typedef struct packed {
    logic req;
    logic [1:0] op;
    logic [4:0] slot;
    logic [1:0] axis;
  } pas_lbreq_t;

  // answer from the module, valid with ack
  typedef struct packed {
    logic ack;
    logic stepping;
    logic [2:0] axisCount;
    logic [31:0] position;
    logic emitting;
    logic halted;
  } pas_lbrsp_t;

  typedef struct packed {
    logic wrPend;
    logic [ADDR_W-1:0] wrAddr;
    logic [31:0] rdata;
    logic readyOut;
  } pas_port_t;
endpackage

// ahb-lite slave front end: zero wait states, read data latched at the address phase
module pas_ahb_port
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] rdValue,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic rdEn,
  output logic [pas_pkg::ADDR_W-1:0] rdAddr,
  output logic wrEn,
  output logic [pas_pkg::ADDR_W-1:0] wrAddr
);
  import pas_pkg::*;

  pas_port_t q;
  pas_port_t d;
  logic take;
  logic mapped;

  // address phase decode; upper address bits must be zero, else unmapped
  assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && (hsize == HSIZE_WORD);
  assign mapped = (haddr[31:ADDR_W] == '0);
  assign rdAddr = haddr[ADDR_W-1:0];
  assign rdEn = take && !hwrite && mapped;
  assign wrEn = q.wrPend;
  assign wrAddr = q.wrAddr;
  assign hreadyout = q.readyOut;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;

  // write applies in the data phase when hwdata is valid
  always_comb
  begin
    d = q;
    d.readyOut = 1'b1;
    d.wrPend = take && hwrite && mapped;
    d.wrAddr = haddr[ADDR_W-1:0];
    if (rdEn)
    begin
      d.rdata = rdValue;
    end
    else if (take)
    begin
      d.rdata = 32'h0000_0000; // unmapped or write reads zero
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '{wrPend: 1'b0, wrAddr: '0, rdata: 32'h0000_0000, readyOut: 1'b1};
    end
    else
    begin
      q <= d;
    end
  end
endmodule

// file: pas_axis_status_properties.sv
// assertions on the ports of the axis read-back block
module pas_axis_status_properties
(
  input wire logic clk,
  input wire logic rstn,
  input wire pas_pkg::pas_lbreq_t lbReq,
  input wire pas_pkg::pas_lbrsp_t lbRsp,
  input wire logic blockActive,
  input wire logic [31:0] currentStepPosition,
  input wire logic outputInProgress,
  input wire logic outputHalted,
  input wire logic faultFlag,
  input wire logic [3:0] faultCode
);
  timeunit 1ns;
  timeprecision 1ps;
  import pas_pkg::*;
  logic rdAck;
  // a status poll answered by a stepping module
  assign rdAck = lbReq.req && lbReq.op == LB_OP_READ && lbRsp.ack && lbRsp.stepping;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  chk_pos_follow: assert property (rdAck ##1 (blockActive && !faultFlag)
    |-> currentStepPosition == $past(lbRsp.position)) else $error("position stale");
  chk_flag_follow: assert property (rdAck ##1 (blockActive && !faultFlag)
    |-> outputHalted == $past(lbRsp.halted)
    && outputInProgress == ($past(lbRsp.emitting) && !$past(lbRsp.halted)))
    else $error("motion flags stale");
  chk_never_both: assert property (!(outputHalted && outputInProgress))
    else $error("halted while moving");
  chk_idle_pos: assert property (!blockActive |-> currentStepPosition == POSITION_RESET)
    else $error("position set while idle");
  chk_idle_flags: assert property (!blockActive |-> !outputInProgress && !outputHalted)
    else $error("motion flag while idle");
  chk_idle_fault: assert property (
    !blockActive |-> !faultFlag && faultCode == NO_FAULT_VALUE) else $error("fault while idle");
  chk_fault_code: assert property ($rose(faultFlag) |-> faultCode != NO_FAULT_VALUE)
    else $error("fault without code");
  chk_not_step: assert property (
    lbReq.req && lbRsp.ack && lbReq.op == LB_OP_READ && !lbRsp.stepping
    |-> ##[1:3] (!blockActive || faultFlag && faultCode == FAULT_NOT_STEPPING))
    else $error("foreign module not flagged");
  chk_req_drop: assert property (lbReq.req && lbRsp.ack |=> !lbReq.req)
    else $error("request held past answer");
  cover property (rdAck && lbRsp.halted);
  cover property ($rose(faultFlag));
  cover property (lbReq.req && lbReq.op == LB_OP_CLEAR && lbRsp.ack);
endmodule

bind pas_axis_status pas_axis_status_properties chk (.clk, .rstn, .lbReq, .lbRsp, .blockActive,
  .currentStepPosition, .outputInProgress, .outputHalted, .faultFlag, .faultCode);

// file: pas_lb_model.sv
// behavioural stepping output module on the local bus
module pas_lb_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire pas_pkg::pas_lbreq_t lbReq,
  input wire logic isStepping,
  input wire logic [2:0] axisCnt,
  input wire logic emitting,
  input wire logic halted,
  input wire logic [3:0] lag,
  output pas_pkg::pas_lbrsp_t lbRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import pas_pkg::*;
  logic [31:0] posQ;
  logic [3:0] waitQ;
  pas_lbrsp_t rspQ;
  // count kept here so it outlasts every run; a halt holds it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      posQ <= 32'h0000_0000;
      waitQ <= 4'h0;
      rspQ <= '0;
    end
    else
    begin
      rspQ.ack <= 1'b0;
      if (emitting && !halted)
        posQ <= posQ + 32'h0000_0001;
      if (!lbReq.req || rspQ.ack)
        waitQ <= 4'h0;
      else if (waitQ != lag)
        waitQ <= waitQ + 4'h1;
      else
      begin
        rspQ <= '{1'b1, isStepping, axisCnt, posQ, emitting, halted};
        if (lbReq.op == LB_OP_CLEAR)
          posQ <= 32'h0000_0000;
      end
    end
  end
  // between answers the lines show the inverse, so stale data never looks valid
  assign lbRsp = rspQ.ack ? rspQ : {1'b0, ~rspQ[37:0]};
endmodule

// file: pulse_axis_status_readback_test.sv
// self-checking bench for the axis status read-back block
module pulse_axis_status_readback_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pas_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, currentStepPosition;
  logic hreadyout, hresp, blockActive, outputInProgress, outputHalted, faultFlag, irq;
  logic [3:0] faultCode;
  logic isStepping = 1'b1;
  logic emitting = 1'b0;
  logic halted = 1'b0;
  logic [3:0] lag = 4'h0;
  pas_lbreq_t lbReq;
  pas_lbrsp_t lbRsp;
  int fails = 0;
  int totalChecks = 0;
  // the one slave's ready is the bus ready
  pas_axis_status dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hreadyout, .hresp, .hrdata, .lbReq, .lbRsp, .blockActive, .currentStepPosition,
    .outputInProgress, .outputHalted, .faultFlag, .faultCode, .irq);
  pas_lb_model partner (.clk, .rstn, .lbReq, .isStepping, .axisCnt(3'h2), .emitting, .halted,
    .lag, .lbRsp);
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer; each phase held until ready is seen
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0000_0000, v);
    check(what, v, exp);
    check("ready and resp", {hreadyout, hresp}, 2'b10);
  endtask
  // bounded wait for n answers, then two edges for the outputs to follow
  task automatic waitAcks(input int n);
    int t;
    t = 0;
    while (n > 0 && t < 400)
    begin
      @(posedge clk);
      t++;
      if (lbRsp.ack === 1'b1)
        n--;
    end
    check("ack count", n, 0);
    repeat (2) @(posedge clk);
  endtask
  task automatic idleChk();
    check("idle", {blockActive, outputInProgress, outputHalted, faultFlag, faultCode}, 0);
    check("idle pos", currentStepPosition, 32'h0000_0000);
  endtask
  task automatic testReset();
    idleChk();
    rdReg(SELECT_OFS, 32'h0000_0100, "select");
    rdReg(IRQ_MASK_OFS, 32'h0000_0000, "mask");
    rdReg(8'h1C, 32'h0000_0000, "unmapped");
    $display("done reset");
  endtask
  // ten pulses, a pause at zero rate, then a resume
  task automatic testMotion();
    wr(CTRL_OFS, 32'h0000_0001);
    waitAcks(2);
    check("active", blockActive, 1'b1);
    emitting <= 1'b1;
    repeat (8) @(posedge clk);
    check("moving", {outputInProgress, outputHalted}, 2'b10);
    repeat (2) @(posedge clk);
    emitting <= 1'b0;
    waitAcks(2);
    check("pos", currentStepPosition, 32'h0000_000A);
    check("ready", {outputInProgress, outputHalted}, 2'b00);
    rdReg(POSITION_OFS, 32'h0000_000A, "pos reg");
    rdReg(CTRL_OFS, 32'h0000_0001, "ctrl reg");
    {emitting, halted} <= 2'b11;
    waitAcks(2);
    check("paused", {outputInProgress, outputHalted}, 2'b01);
    rdReg(STATUS_OFS, 32'h0000_0005, "status");
    halted <= 1'b0;
    waitAcks(2);
    check("resumed", {outputInProgress, outputHalted}, 2'b10);
    emitting <= 1'b0;
    $display("done motion");
  endtask
  // clear edge while running, clear held, release and restart on a slow module
  task automatic testClear();
    lag <= 4'h5;
    wr(CTRL_OFS, 32'h0000_0003);
    waitAcks(3);
    check("cleared", currentStepPosition, 32'h0000_0000);
    emitting <= 1'b1;
    repeat (5) @(posedge clk);
    emitting <= 1'b0;
    waitAcks(2);
    check("held clear", currentStepPosition, 32'h0000_0005);
    wr(CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    idleChk();
    wr(CTRL_OFS, 32'h0000_0001);
    waitAcks(2);
    check("kept", currentStepPosition, 32'h0000_0005);
    wr(CTRL_OFS, 32'h0000_0000);
    $display("done clear");
  endtask
  // each bad selection, then a legal boundary one; irq masked on the first
  task automatic testFaults();
    logic [31:0] sel [6] = '{32'h0000_0120, 32'h0000_0000, 32'h0000_0500, 32'h0000_0101,
      32'h0000_0300, 32'h0000_021F};
    logic [3:0] code [6] = '{FAULT_SLOT_RANGE, FAULT_AXIS_RANGE, FAULT_AXIS_RANGE,
      FAULT_NOT_STEPPING, FAULT_AXIS_ABSENT, NO_FAULT_VALUE};
    logic [31:0] v;
    int t;
    bus(IRQ_STATUS_OFS, 1'b0, 32'h0000_0000, v);
    for (int i = 0; i < 6; i++)
    begin
      isStepping <= (i != 3);
      wr(IRQ_MASK_OFS, {31'h0000_0000, i != 0});
      wr(SELECT_OFS, sel[i]);
      wr(CTRL_OFS, 32'h0000_0001);
      for (t = 0; t < 40 && faultFlag !== 1'b1; t++)
        @(posedge clk);
      repeat (2) @(posedge clk);
      check("fault", {faultFlag, faultCode}, {code[i] != 0, code[i]});
      rdReg(FAULT_OFS, {28'h000_0000, code[i]}, "fault reg");
      check("irq", irq, i != 0 && code[i] != 0);
      rdReg(IRQ_STATUS_OFS, {31'h0000_0000, code[i] != 0}, "irq status");
      repeat (3) @(posedge clk);
      check("irq off", irq, 1'b0);
      wr(CTRL_OFS, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check("fault off", {faultFlag, faultCode}, 5'h00);
    end
    $display("done faults");
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // reset for twenty cycles, then the scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    testReset();
    testMotion();
    testClear();
    testFaults();
    endOfTest();
  end
  // the scenarios need a few thousand cycles at most
  initial
  begin
    #100000;
    fails++;
    endOfTest();
  end
endmodule
